// ==== scc_pkg.sv ====
// Shared constants and types of the stroke curve characterizer
package scc_pkg;

    localparam int SCC_NPTS = 21;
    localparam int SCC_VW   = 16;
    localparam int SCC_DW   = 30;
    localparam int SCC_CW   = 5;

    // Register byte offsets and curve table byte span
    localparam logic [11:0] SCC_OFF_MODE   = 12'h000;
    localparam logic [11:0] SCC_OFF_FLAGS  = 12'h004;
    localparam logic [11:0] SCC_OFF_STATUS = 12'h008;
    localparam logic [11:0] SCC_OFF_OUTPUT = 12'h00C;
    localparam logic [11:0] SCC_OFF_SIGCTL = 12'h010;
    localparam logic [11:0] SCC_OFF_X_BASE = 12'h040;
    localparam logic [11:0] SCC_OFF_Y_BASE = 12'h100;
    localparam logic [11:0] SCC_OFF_SPAN   = 12'h054;

    // Field positions and flags width
    localparam int SCC_MODE_OOS_BIT   = 0;
    localparam int SCC_FLAG_QO_BIT    = 1;
    localparam int SCC_FLAG_EQ_BIT    = 2;
    localparam int SCC_FLAG_CUST_BIT  = 6;
    localparam int SCC_SIG_BEGIN_BIT  = 0;
    localparam int SCC_FLAGS_W        = 9;

    // Reset values
    localparam logic                   SCC_MODE_RST  = 1'b0;
    localparam logic [SCC_FLAGS_W-1:0] SCC_FLAGS_RST = 9'h000;

    // Point range in hundredths of a percent
    localparam logic signed [15:0] SCC_PT_MIN = 16'hFC18;
    localparam logic signed [15:0] SCC_PT_MAX = 16'h2AF8;

    // AXI responses
    localparam logic [1:0] SCC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] SCC_RESP_SLVERR = 2'h2;

    typedef logic signed [15:0] scc_pt_t;
    typedef scc_pt_t scc_curve_t [SCC_NPTS];

    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  strb;
    } scc_wdat_t;

    localparam scc_curve_t SCC_FAC_X = '{
        16'h0000, 16'h01F4, 16'h03E8, 16'h05DC, 16'h07D0, 16'h09C4,
        16'h0BB8, 16'h0DAC, 16'h0FA0, 16'h1194, 16'h1388, 16'h157C,
        16'h1770, 16'h1964, 16'h1B58, 16'h1D4C, 16'h1F40, 16'h2134,
        16'h2328, 16'h251C, 16'h2710};
    localparam scc_curve_t SCC_QO_Y = '{
        16'h0000, 16'h0758, 16'h0EB0, 16'h1608, 16'h1CE8, 16'h20EE,
        16'h2328, 16'h23F0, 16'h247C, 16'h24CC, 16'h2508, 16'h254E,
        16'h2580, 16'h25B2, 16'h25E4, 16'h2616, 16'h2648, 16'h267A,
        16'h26AC, 16'h26DE, 16'h2710};
    localparam scc_curve_t SCC_EQ_Y = '{
        16'h0000, 16'h0064, 16'h00C8, 16'h012C, 16'h0190, 16'h020C,
        16'h0287, 16'h0322, 16'h03BD, 16'h04A2, 16'h0587, 16'h06DA,
        16'h082D, 16'h0A22, 16'h0C17, 16'h0EFC, 16'h11E1, 16'h15BE,
        16'h1A70, 16'h2027, 16'h2710};

endpackage

// ==== scc_characterizer.sv ====
// Stroke curve characterizer with AXI4-Lite register access
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
module scc_characterizer (
    // Clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // AXI4-Lite write
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Commanded position in
    input  wire logic [15:0] cmd_pos,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    // Shaped command out
    output logic [15:0]      shaped_pos,
    output logic             shaped_valid,
    // Signature start pulse
    output logic             sig_start
);

    typedef enum {SCC_IDLE, SCC_SCAN, SCC_DIV} scc_state_t;

    // Bus and register state
    logic [11:0]               aw_addr_reg, aw_addr_next;
    logic                      aw_full_reg, aw_full_next;
    scc_pkg::scc_wdat_t        w_reg, w_next;
    logic                      w_full_reg, w_full_next;
    logic                      bvalid_reg, bvalid_next;
    logic [1:0]                bresp_reg, bresp_next;
    logic                      rvalid_reg, rvalid_next;
    logic [31:0]               rdata_reg, rdata_next;
    logic                      oos_reg, oos_next;
    logic [scc_pkg::SCC_FLAGS_W-1:0] flags_reg, flags_next;
    logic                      sigref_reg, sigref_next;
    logic                      sig_reg, sig_next;
    scc_pkg::scc_curve_t       nvx_reg, nvx_next, nvy_reg, nvy_next;
    scc_pkg::scc_curve_t       wx, wy;

    // Datapath state
    scc_state_t                st_reg, st_next;
    logic [4:0]                idx_reg, idx_next;
    scc_pkg::scc_pt_t          x_reg, x_next;
    scc_pkg::scc_pt_t          out_reg, out_next;
    logic                      ov_reg, ov_next;
    logic [scc_pkg::SCC_DW-1:0] dq_reg, dq_next;
    logic [14:0]               rm_reg, rm_next;
    logic [14:0]               den_reg, den_next;
    logic                      neg_reg, neg_next;
    logic [scc_pkg::SCC_CW-1:0] cnt_reg, cnt_next;

    logic                      qo_sel, eq_sel, cust_en;
    logic                      wr_fire, rd_fire;
    logic [11:0]               wa, xo, yo, ra, rxo, ryo;
    logic                      wa_x, wa_y, ra_x, ra_y, edit_ok, in_rng;
    logic [4:0]                widx, ridx;
    scc_pkg::scc_pt_t          wold, wnew;

    assign qo_sel  = flags_reg[scc_pkg::SCC_FLAG_QO_BIT];
    assign eq_sel  = flags_reg[scc_pkg::SCC_FLAG_EQ_BIT];
    assign cust_en = flags_reg[scc_pkg::SCC_FLAG_CUST_BIT];

    // Working curve: factory overlay on top of the stored curve
    for (genvar k = 0; k < scc_pkg::SCC_NPTS; k++) begin : g_work
        always_comb begin
            if (qo_sel) begin
                wx[k] = scc_pkg::SCC_FAC_X[k];
                wy[k] = scc_pkg::SCC_QO_Y[k];
            end else if (eq_sel) begin
                wx[k] = scc_pkg::SCC_FAC_X[k];
                wy[k] = scc_pkg::SCC_EQ_Y[k];
            end else begin
                wx[k] = nvx_reg[k];
                wy[k] = nvy_reg[k];
            end
        end
    end

    // Address decode
    assign wa   = aw_addr_reg;
    assign xo   = wa - scc_pkg::SCC_OFF_X_BASE;
    assign yo   = wa - scc_pkg::SCC_OFF_Y_BASE;
    assign wa_x = (xo < scc_pkg::SCC_OFF_SPAN) && (wa[1:0] == 2'h0);
    assign wa_y = (yo < scc_pkg::SCC_OFF_SPAN) && (wa[1:0] == 2'h0);
    assign widx = wa_x ? xo[6:2] : yo[6:2];
    assign ra   = s_axi_araddr;
    assign rxo  = ra - scc_pkg::SCC_OFF_X_BASE;
    assign ryo  = ra - scc_pkg::SCC_OFF_Y_BASE;
    assign ra_x = (rxo < scc_pkg::SCC_OFF_SPAN) && (ra[1:0] == 2'h0);
    assign ra_y = (ryo < scc_pkg::SCC_OFF_SPAN) && (ra[1:0] == 2'h0);
    assign ridx = ra_x ? rxo[6:2] : ryo[6:2];

    assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
    assign rd_fire = s_axi_arvalid && !rvalid_reg;
    assign wold    = wa_x ? nvx_reg[widx] : nvy_reg[widx];
    assign wnew    = {w_reg.strb[1] ? w_reg.data[15:8] : wold[15:8],
                      w_reg.strb[0] ? w_reg.data[7:0]  : wold[7:0]};
    assign in_rng  = (wnew >= scc_pkg::SCC_PT_MIN) &&
                     (wnew <= scc_pkg::SCC_PT_MAX);
    assign edit_ok = oos_reg && !qo_sel && !eq_sel;

    // Bus slave and register file next values
    always_comb begin
        aw_addr_next = aw_addr_reg;
        aw_full_next = aw_full_reg;
        w_next       = w_reg;
        w_full_next  = w_full_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        oos_next     = oos_reg;
        flags_next   = flags_reg;
        sigref_next  = sigref_reg;
        sig_next     = 1'b0;
        nvx_next     = nvx_reg;
        nvy_next     = nvy_reg;
        if (s_axi_awvalid && !aw_full_reg) begin
            aw_addr_next = s_axi_awaddr;
            aw_full_next = 1'b1;
        end
        if (s_axi_wvalid && !w_full_reg) begin
            w_next      = '{data: s_axi_wdata, strb: s_axi_wstrb};
            w_full_next = 1'b1;
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (wr_fire) begin
            aw_full_next = 1'b0;
            w_full_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = scc_pkg::SCC_RESP_OKAY;
            if (wa == scc_pkg::SCC_OFF_MODE) begin
                if (w_reg.strb[0]) begin
                    oos_next = w_reg.data[scc_pkg::SCC_MODE_OOS_BIT];
                end
            end else if (wa == scc_pkg::SCC_OFF_FLAGS) begin
                if (oos_reg) begin
                    if (w_reg.strb[0]) begin
                        flags_next[7:0] = w_reg.data[7:0];
                    end
                    if (w_reg.strb[1]) begin
                        flags_next[8] = w_reg.data[8];
                    end
                end else begin
                    bresp_next = scc_pkg::SCC_RESP_SLVERR;
                end
            end else if (wa == scc_pkg::SCC_OFF_SIGCTL) begin
                if (w_reg.strb[0] &&
                    w_reg.data[scc_pkg::SCC_SIG_BEGIN_BIT]) begin
                    sig_next    = oos_reg;
                    sigref_next = !oos_reg;
                end
            end else if (wa_x || wa_y) begin
                if (edit_ok && in_rng) begin
                    if (wa_x) begin
                        nvx_next[widx] = wnew;
                    end else begin
                        nvy_next[widx] = wnew;
                    end
                end else begin
                    bresp_next = scc_pkg::SCC_RESP_SLVERR;
                end
            end else if (wa != scc_pkg::SCC_OFF_STATUS &&
                         wa != scc_pkg::SCC_OFF_OUTPUT) begin
                bresp_next = scc_pkg::SCC_RESP_SLVERR;
            end
        end
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (rd_fire) begin
            rvalid_next = 1'b1;
            rdata_next  = 32'h0000_0000;
            if (ra == scc_pkg::SCC_OFF_MODE) begin
                rdata_next[0] = oos_reg;
            end else if (ra == scc_pkg::SCC_OFF_FLAGS) begin
                rdata_next[scc_pkg::SCC_FLAGS_W-1:0] = flags_reg;
            end else if (ra == scc_pkg::SCC_OFF_STATUS) begin
                rdata_next[5:0] = {st_reg != SCC_IDLE, sigref_reg,
                                   eq_sel && !qo_sel, qo_sel, cust_en,
                                   oos_reg};
            end else if (ra == scc_pkg::SCC_OFF_OUTPUT) begin
                rdata_next[15:0] = out_reg;
            end else if (ra_x) begin
                rdata_next[15:0] = wx[ridx];
            end else if (ra_y) begin
                rdata_next[15:0] = wy[ridx];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_reg <= 12'h000;
            aw_full_reg <= 1'b0;
            w_reg       <= '0;
            w_full_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= scc_pkg::SCC_RESP_OKAY;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            oos_reg     <= scc_pkg::SCC_MODE_RST;
            flags_reg   <= scc_pkg::SCC_FLAGS_RST;
            sigref_reg  <= 1'b0;
            sig_reg     <= 1'b0;
            nvx_reg     <= scc_pkg::SCC_FAC_X;
            nvy_reg     <= scc_pkg::SCC_FAC_X;
        end else if (ce) begin
            aw_addr_reg <= aw_addr_next;
            aw_full_reg <= aw_full_next;
            w_reg       <= w_next;
            w_full_reg  <= w_full_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            oos_reg     <= oos_next;
            flags_reg   <= flags_next;
            sigref_reg  <= sigref_next;
            sig_reg     <= sig_next;
            nvx_reg     <= nvx_next;
            nvy_reg     <= nvy_next;
        end
    end

    assign s_axi_awready = !aw_full_reg;
    assign s_axi_wready  = !w_full_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = scc_pkg::SCC_RESP_OKAY;
    assign sig_start     = sig_reg;

    // Shaping datapath
    logic signed [16:0] dx, dy, dd;
    logic [15:0]        trial;
    logic [29:0]        prod;

    assign dx    = 17'(x_reg) - 17'(wx[idx_reg]);
    assign dy    = 17'(wy[idx_reg + 5'd1]) - 17'(wy[idx_reg]);
    assign dd    = 17'(wx[idx_reg + 5'd1]) - 17'(wx[idx_reg]);
    assign prod  = 30'(dx[14:0]) * 30'(dy[16] ? 15'(-dy) : dy[14:0]);
    assign trial = {rm_reg, dq_reg[scc_pkg::SCC_DW-1]};

    always_comb begin
        st_next  = st_reg;
        idx_next = idx_reg;
        x_next   = x_reg;
        out_next = out_reg;
        ov_next  = 1'b0;
        dq_next  = dq_reg;
        rm_next  = rm_reg;
        den_next = den_reg;
        neg_next = neg_reg;
        cnt_next = cnt_reg;
        case (st_reg)
            SCC_IDLE: begin
                if (cmd_valid) begin
                    x_next   = cmd_pos;
                    idx_next = 5'd0;
                    if (!cust_en && !qo_sel && !eq_sel) begin
                        out_next = cmd_pos;
                        ov_next  = 1'b1;
                    end else begin
                        st_next = SCC_SCAN;
                    end
                end
            end
            SCC_SCAN: begin
                if (idx_reg == 5'd0 && x_reg <= wx[0]) begin
                    out_next = wy[0];
                    ov_next  = 1'b1;
                    st_next  = SCC_IDLE;
                end else if (x_reg < wx[idx_reg + 5'd1]) begin
                    dq_next  = prod;
                    rm_next  = 15'h0000;
                    den_next = dd[14:0];
                    neg_next = dy[16];
                    cnt_next = '0;
                    st_next  = SCC_DIV;
                end else if (idx_reg == 5'(scc_pkg::SCC_NPTS - 2)) begin
                    out_next = wy[scc_pkg::SCC_NPTS-1];
                    ov_next  = 1'b1;
                    st_next  = SCC_IDLE;
                end else begin
                    idx_next = idx_reg + 5'd1;
                end
            end
            SCC_DIV: begin
                if (trial >= {1'b0, den_reg}) begin
                    rm_next = 15'(trial - {1'b0, den_reg});
                    dq_next = {dq_reg[scc_pkg::SCC_DW-2:0], 1'b1};
                end else begin
                    rm_next = trial[14:0];
                    dq_next = {dq_reg[scc_pkg::SCC_DW-2:0], 1'b0};
                end
                cnt_next = cnt_reg + 5'd1;
                if (cnt_reg == 5'(scc_pkg::SCC_DW - 1)) begin
                    out_next = neg_reg ? wy[idx_reg] - 16'(dq_next)
                                       : wy[idx_reg] + 16'(dq_next);
                    ov_next  = 1'b1;
                    st_next  = SCC_IDLE;
                end
            end
            default: st_next = SCC_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg  <= SCC_IDLE;
            idx_reg <= 5'd0;
            x_reg   <= 16'h0000;
            out_reg <= 16'h0000;
            ov_reg  <= 1'b0;
            dq_reg  <= '0;
            rm_reg  <= 15'h0000;
            den_reg <= 15'h0000;
            neg_reg <= 1'b0;
            cnt_reg <= '0;
        end else if (ce) begin
            st_reg  <= st_next;
            idx_reg <= idx_next;
            x_reg   <= x_next;
            out_reg <= out_next;
            ov_reg  <= ov_next;
            dq_reg  <= dq_next;
            rm_reg  <= rm_next;
            den_reg <= den_next;
            neg_reg <= neg_next;
            cnt_reg <= cnt_next;
        end
    end

    assign cmd_ready    = (st_reg == SCC_IDLE);
    assign shaped_pos   = out_reg;
    assign shaped_valid = ov_reg;

    // Checks
    default clocking cb_chk @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_curve_wr;
        wr_fire && (wa_x || wa_y);
    endsequence

    a_edit_gate_oos: assert property (
        ((ce && !oos_reg) and s_curve_wr) |=> bvalid_reg &&
        bresp_reg == scc_pkg::SCC_RESP_SLVERR && $stable(nvx_reg[0]))
        else $error("curve edit taken in service");
    a_range_refuse: assert property (
        ((ce && !in_rng) and s_curve_wr) |=>
        bresp_reg == scc_pkg::SCC_RESP_SLVERR)
        else $error("out of range point taken");
    a_qo_overlay: assert property (
        qo_sel |-> wy[5] == scc_pkg::SCC_QO_Y[5] && wx[20] == 16'h2710)
        else $error("quick-open curve not in working copy");
    a_eq_overlay: assert property (
        eq_sel && !qo_sel |-> wy[19] == scc_pkg::SCC_EQ_Y[19])
        else $error("equal-percent curve not in working copy");
    a_qo_wins: assert property (
        qo_sel && eq_sel |-> wy[10] == scc_pkg::SCC_QO_Y[10])
        else $error("equal-percent overrode quick-open");
    a_restore_stored: assert property (
        $fell(qo_sel || eq_sel) |-> wy[7] == nvy_reg[7] && wx[7] == nvx_reg[7])
        else $error("stored curve not restored");
    a_nv_untouched: assert property (
        ce && !(wr_fire && (wa_x || wa_y)) |=>
        $stable(nvy_reg[3]) && $stable(nvx_reg[3]))
        else $error("stored curve changed without edit");
    a_linear_pass: assert property (
        ce && st_reg == SCC_IDLE && cmd_valid && !cust_en && !qo_sel &&
        !eq_sel |=> ov_reg && out_reg == $past(cmd_pos))
        else $error("linear mode not one to one");
    a_clamp_low: assert property (
        ce && st_reg == SCC_SCAN && idx_reg == 5'd0 && x_reg <= wx[0]
        |=> ov_reg && out_reg == $past(wy[0]))
        else $error("low clamp wrong");
    a_interp_bound: assert property (
        ce && st_reg == SCC_DIV && st_next == SCC_IDLE |=> ov_reg &&
        (out_reg >= $past(wy[idx_reg]) || out_reg >= $past(wy[idx_reg+5'd1]))
        && (out_reg <= $past(wy[idx_reg]) ||
        out_reg <= $past(wy[idx_reg+5'd1])))
        else $error("interpolation outside segment");
    a_sig_refuse: assert property (
        sig_reg |-> $past(oos_reg))
        else $error("signature started in service");

endmodule

// ==== scc_host.sv ====
// AXI4-Lite master model of the configuring host
`timescale 1ns/1ns
module scc_host (
    // Clock
    input  wire logic        aclk,
    // Write channels
    output logic [11:0]      awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    // Read channels
    output logic [11:0]      araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic        rvalid,
    output logic             rready
);
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // Write: both channels offered together, each dropped when taken
    task automatic put(input logic [11:0] a, input logic [31:0] d,
                       output logic [1:0] r);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr  <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata  <= ~d;
            end
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask
    // Read: address held until taken, data taken with rvalid
    task automatic get(input logic [11:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr  <= ~a;
            end
            if (rvalid) begin
                d = rdata;
                rready <= 1'b0;
                break;
            end
        end
    endtask
endmodule

// ==== scc_characterizer_bench.sv ====
// Self-checking bench of the stroke curve characterizer
`timescale 1ns/1ns
module scc_characterizer_bench;
    typedef struct {
        logic [1:0]  op;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } scc_row_t;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, got;
    logic [1:0]  bresp, resp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [15:0] cmd_pos = 16'h0000;
    logic [15:0] shaped_pos;
    logic        cmd_valid = 1'b0;
    logic        cmd_ready, shaped_valid, sig_start;
    int          n_mismatch = 0, compares = 0, cycles = 0, n_sig = 0;
    scc_row_t    rows [$];

    scc_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rvalid(rvalid), .rready(rready));
    scc_characterizer DUT (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmd_pos(cmd_pos),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .shaped_pos(shaped_pos), .shaped_valid(shaped_valid),
        .sig_start(sig_start));

    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles++;
        if (sig_start)
            n_sig++;
        if (cycles == 20000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, e);
        compares++;
        if (seen !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, e, seen);
        end
    endtask
    task automatic results();
        $display("Compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic add(input logic [1:0] op, input logic [11:0] a,
                       input logic [31:0] d, e);
        rows.push_back('{op, a, d, e});
    endtask
    // Offers one command and waits for its shaped result
    task automatic run_cmd(input logic [15:0] p, output logic [31:0] y);
        @(posedge aclk);
        cmd_pos   <= p;
        cmd_valid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (cmd_ready)
                cmd_valid <= 1'b0;
            if (shaped_valid) begin
                y = {16'h0000, shaped_pos};
                break;
            end
        end
    endtask

    initial begin
        add(2'h0, 12'h004, 32'h40, 32'h2);
        add(2'h0, 12'h010, 32'h1, 32'h0);
        add(2'h1, 12'h008, 32'h0, 32'h10);
        add(2'h1, 12'h200, 32'h0, 32'h0);
        add(2'h0, 12'h200, 32'h1, 32'h2);
        add(2'h0, 12'h104, 32'h3E8, 32'h2);
        add(2'h0, 12'h000, 32'h1, 32'h0);
        add(2'h0, 12'h010, 32'h1, 32'h0);
        add(2'h1, 12'h008, 32'h0, 32'h1);
        add(2'h0, 12'h044, 32'h2AF9, 32'h2);
        add(2'h0, 12'h104, 32'h3E8, 32'h0);
        add(2'h0, 12'h108, 32'h1F4, 32'h0);
        add(2'h0, 12'h004, 32'h40, 32'h0);
        add(2'h2, 12'h000, 32'hFA, 32'h1F4);
        add(2'h2, 12'h000, 32'h2EE, 32'h2EE);
        add(2'h2, 12'h000, 32'hFE0C, 32'h0);
        add(2'h2, 12'h000, 32'h2AF8, 32'h2710);
        add(2'h0, 12'h004, 32'h42, 32'h0);
        add(2'h2, 12'h000, 32'h1F4, 32'h758);
        add(2'h1, 12'h104, 32'h0, 32'h758);
        add(2'h0, 12'h004, 32'h44, 32'h0);
        add(2'h2, 12'h000, 32'h1F4, 32'h64);
        add(2'h0, 12'h004, 32'h46, 32'h0);
        add(2'h2, 12'h000, 32'h1F4, 32'h758);
        add(2'h0, 12'h004, 32'h40, 32'h0);
        add(2'h2, 12'h000, 32'hFA, 32'h1F4);
        add(2'h1, 12'h104, 32'h0, 32'h3E8);
        add(2'h0, 12'h004, 32'h0, 32'h0);
        add(2'h0, 12'h150, 32'h2AF8, 32'h0);
        add(2'h0, 12'h090, 32'h2AF8, 32'h0);
        add(2'h0, 12'h004, 32'h40, 32'h0);
        add(2'h2, 12'h000, 32'h2904, 32'h2904);
        add(2'h0, 12'h004, 32'h0, 32'h0);
        add(2'h2, 12'h000, 32'hFA, 32'hFA);
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            case (rows[i].op)
                2'h0: begin
                    host.put(rows[i].a, rows[i].d, resp);
                    got = {30'h0, resp};
                end
                2'h1: host.get(rows[i].a, got);
                default: run_cmd(rows[i].d[15:0], got);
            endcase
            check($sformatf("row %0d", i), got, rows[i].e);
        end
        check("signature pulses", n_sig, 32'h1);
        // Second reset in mid-run returns to linear and in service
        @(posedge aclk);
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        host.get(12'h000, got);
        check("mode after reset", got, 32'h0);
        check("shaped after reset", {16'h0, shaped_pos}, 32'h0);
        check("read response", {30'h0, rresp}, 32'h0);
        // Back-to-back linear commands, looked at once settled
        @(posedge aclk);
        cmd_pos   <= 16'h0100;
        cmd_valid <= 1'b1;
        @(posedge aclk);
        cmd_pos <= 16'h0200;
        #1 check("first linear", {16'h0, shaped_pos}, 32'h100);
        check("first valid", {31'h0, shaped_valid}, 32'h1);
        @(posedge aclk);
        cmd_valid <= 1'b0;
        #1 check("second linear", {16'h0, shaped_pos}, 32'h200);
        check("second valid", {31'h0, shaped_valid}, 32'h1);
        @(posedge aclk);
        #1 check("valid drops", {31'h0, shaped_valid}, 32'h0);
        results();
    end
endmodule
